// *** core/shs_pkg.sv ***
// Shared constants and types of the standby controller.
package shs_pkg;
    // ==================================================
    // Register map and field layout
    // ==================================================
    localparam logic [1:0] ADDR_SEL    = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_OPT    = 2'h2;
    localparam logic [1:0] ADDR_STATE  = 2'h3;
    localparam logic [2:0] SEL_RST     = 3'h7;
    localparam logic [7:0] OPT_RST     = 8'h00;
    localparam int         OPT_WDT_EN  = 4;
    localparam int         OPT_WDT_SLP = 0;
    localparam int         STAB_BITS   = 8;
    localparam int         STAB_CNT_W  = 19;
    // Threshold exponents, one per status bit, shortest first.
    localparam logic [39:0] STAB_EXP   = {5'h12, 5'h11, 5'h0f, 5'h0d,
                                          5'h0b, 5'h0a, 5'h09, 5'h08};

    // ==================================================
    // Timing
    // ==================================================
    localparam int CLK_MHZ         = 100;
    localparam int LONG_WAKE_US    = 61;
    localparam int LONG_WAKE_CYC   = LONG_WAKE_US * CLK_MHZ;
    localparam int FAST_SETTLE_NS  = 200;
    localparam int FAST_SETTLE_CYC = (FAST_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int WAIT_W          = 14;

    // ==================================================
    // Types
    // ==================================================
    typedef enum logic [2:0] {
        SRC_FAST, SRC_DSC, SRC_XTAL, SRC_EXT, SRC_SUB
    } shs_src_t;

    typedef enum logic [1:0] {
        ST_RUN, ST_HALT, ST_STOP, ST_STAB
    } shs_state_t;

    typedef struct packed {
        logic fast;
        logic dsc;
        logic xtal;
        logic ext;
        logic sub;
    } shs_osc_t;

    typedef struct packed {
        logic timer_array;
        logic inverter;
        logic adc;
        logic amp;
        logic comp;
        logic serial_array;
        logic muldiv;
        logic dma;
        logic rtc;
        logic ext_irq;
    } shs_periph_t;
endpackage

// *** core/shs_sync2.sv ***
// Two-stage synchroniser for one asynchronous level.
`timescale 1ns/10ps
module shs_sync2 (
    // Clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // Level in and out
    input  wire logic din,
    output logic      dout
);
    logic [1:0] ff_reg;

    // The first stage feeds only the second one.
    always_ff @(posedge clock)
    begin
        if (srst)
            ff_reg <= 2'h0;
        else
            ff_reg <= {ff_reg[0], din};
    end

    assign dout = ff_reg[1];
endmodule // shs_sync2

// *** core/shs_stab_counter.sv ***
// Oscillation stabilization counter with sticky threshold status.
`timescale 1ns/10ps
module shs_stab_counter (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // Control
    input  wire logic       clear,
    input  wire logic       tick,
    input  wire logic [2:0] sel,
    // Status
    output logic [7:0]      status,
    output logic            done
);
    typedef struct packed {
        logic [shs_pkg::STAB_CNT_W-1:0] cnt;
        logic [7:0]                     stat;
    } shs_cnt_st_t;

    shs_cnt_st_t s_reg;
    shs_cnt_st_t s_next;
    logic [shs_pkg::STAB_CNT_W-1:0] top;

    assign top = shs_pkg::STAB_CNT_W'(1) << shs_pkg::STAB_EXP[5*7 +: 5];

    // Count ticks up to the longest threshold; bits rise in order and stay up.
    always_comb
    begin
        s_next = s_reg;
        if (clear)
            s_next = '0;
        else if (tick && s_reg.cnt != top)
            s_next.cnt = s_reg.cnt + 1'b1;
        for (int i = 0; i < shs_pkg::STAB_BITS; i++)
        begin
            if (!clear && i <= int'(sel)
                && s_next.cnt >= (shs_pkg::STAB_CNT_W'(1) << shs_pkg::STAB_EXP[5*i +: 5]))
                s_next.stat[7-i] = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    // Status bit 7 is the first threshold, the counted wait ends at the selected bit.
    assign status = s_reg.stat;
    assign done   = s_reg.stat[3'h7 - sel];
endmodule // shs_stab_counter

// *** core/shs_ctrl.sv ***
// Standby controller: light sleep, deep sleep and stabilization wait.
// Behaviour
// - Halt instruction enters light sleep from any CPU clock source.
// - Light sleep gates CPU clock, stops CPU and flash, keeps RAM and latches.
// - Light sleep keeps CPU main clock on, others keep prior state.
// - Slow oscillator in sleep runs only if watchdog enable and sleep-run bits set.
// - Watchdog in sleep runs only if both option bits are one.
// - Light sleep from subsystem clock: flash low-power, inverter and converter off.
// - Unmasked interrupt ends light sleep; vectored if enabled, else next instruction.
// - Reset ends light sleep and starts from the reset vector.
// - Stop enters deep sleep only from fast, crystal or external main clock.
// - Stop with a pending unmasked interrupt drops straight to the wait.
// - Deep sleep stops all main clocks, subsystem clock keeps prior state.
// - Short waits keep the light-sleep state no longer than 61 us plus wait; here the wait state holds peripherals off for FAST_SETTLE_CYC cycles.
// - Interrupt ends deep sleep; resume only after the stabilization time.
// - Three-bit select picks 2^8 to 2^18 crystal periods, reset is longest.
// - Status bits rise one by one from the first threshold and stay set.
// - Reset ends deep sleep and starts from the reset vector.
`timescale 1ns/10ps
module shs_ctrl #(
    parameter int LONG_WAKE_CYC = shs_pkg::LONG_WAKE_CYC
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 srst,
    // Register port
    input  wire logic [1:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_we,
    input  wire logic                 reg_re,
    output logic [7:0]                reg_rdata,
    // CPU and interrupt logic
    input  wire logic                 halt_exec,
    input  wire logic                 stop_exec,
    input  wire logic                 irq_pending,
    input  wire logic                 irq_enabled,
    input  wire shs_pkg::shs_src_t    cpu_clk_src,
    output logic                      cpu_clk_en,
    output logic                      resume_vectored,
    output logic                      resume_next,
    output logic                      boot_from_vector,
    // Clock generator and crystal
    input  wire shs_pkg::shs_osc_t    osc_req,
    input  wire logic                 crystal_main_clock,
    output shs_pkg::shs_osc_t         osc_en,
    output logic                      internal_slow_osc_en,
    // Memory and peripherals
    output logic                      flash_run,
    output logic                      flash_lowpwr,
    output logic                      wdt_run,
    output shs_pkg::shs_periph_t      periph_en
);
    // ==================================================
    // State
    // ==================================================
    typedef struct packed {
        shs_pkg::shs_state_t         state;
        shs_pkg::shs_src_t           src;
        logic [2:0]                  sel;
        logic [7:0]                  opt;
        logic [7:0]                  rdata;
        logic [shs_pkg::WAIT_W-1:0]  wait_cnt;
        logic                        cpu_clk_en;
        logic                        flash_run;
        logic                        flash_lowpwr;
        shs_pkg::shs_osc_t           osc_en;
        logic                        slow_en;
        logic                        wdt_run;
        shs_pkg::shs_periph_t        periph;
        logic                        res_vec;
        logic                        res_next;
        logic                        boot;
        logic                        xtal_d;
    } shs_ctrl_st_t;

    shs_ctrl_st_t s_reg;
    shs_ctrl_st_t s_next;

    logic       xtal_sync;
    logic       xtal_tick;
    logic       stab_clear;
    logic       stab_done;
    logic [7:0] stab_status;
    logic       stop_ok;
    logic       sleep_n;
    logic       wdt_opt_on;

    // ==================================================
    // Crystal sampling and stabilization counter
    // ==================================================
    shs_sync2 u_xtal_sync (
        .clock (clock),
        .srst  (srst),
        .din   (crystal_main_clock),
        .dout  (xtal_sync)
    );

    // One tick per crystal period, taken after the synchroniser.
    assign xtal_tick = xtal_sync && !s_reg.xtal_d;

    shs_stab_counter u_stab (
        .clock  (clock),
        .srst   (srst),
        .clear  (stab_clear),
        .tick   (xtal_tick),
        .sel    (s_reg.sel),
        .status (stab_status),
        .done   (stab_done)
    );

    // Double-speed and subsystem sources cannot enter deep sleep.
    assign stop_ok    = cpu_clk_src == shs_pkg::SRC_FAST
                     || cpu_clk_src == shs_pkg::SRC_XTAL
                     || cpu_clk_src == shs_pkg::SRC_EXT;
    // Halt wins over stop, so a halt must not wipe the stabilization status.
    assign stab_clear = s_reg.state == shs_pkg::ST_RUN && !halt_exec && stop_exec && stop_ok;
    assign wdt_opt_on = s_reg.opt[shs_pkg::OPT_WDT_EN] && s_reg.opt[shs_pkg::OPT_WDT_SLP];

    // ==================================================
    // Next state
    // ==================================================
    always_comb
    begin
        s_next          = s_reg;
        s_next.res_vec  = 1'b0;
        s_next.res_next = 1'b0;
        s_next.boot     = 1'b0;
        s_next.xtal_d   = xtal_sync;
        sleep_n         = 1'b1;

        // Register writes; the status register is read only.
        if (reg_we && reg_addr == shs_pkg::ADDR_SEL)
            s_next.sel = reg_wdata[2:0];
        if (reg_we && reg_addr == shs_pkg::ADDR_OPT)
            s_next.opt = reg_wdata;

        // Read data stand only in the cycle after the strobe.
        s_next.rdata = 8'h00;
        if (reg_re)
        begin
            case (reg_addr)
                shs_pkg::ADDR_SEL:    s_next.rdata = {5'h00, s_reg.sel};
                shs_pkg::ADDR_STATUS: s_next.rdata = stab_status;
                shs_pkg::ADDR_OPT:    s_next.rdata = s_reg.opt;
                default:              s_next.rdata = {6'h00, s_reg.state};
            endcase
        end

        // Standby sequencing.
        case (s_reg.state)
            shs_pkg::ST_RUN:
            begin
                if (halt_exec)
                begin
                    s_next.state = shs_pkg::ST_HALT;
                    s_next.src   = cpu_clk_src;
                end
                else if (stop_exec && stop_ok)
                begin
                    s_next.src      = cpu_clk_src;
                    s_next.wait_cnt = '0;
                    // A pending request turns deep sleep into the wait at once.
                    if (irq_pending)
                        s_next.state = shs_pkg::ST_STAB;
                    else
                        s_next.state = shs_pkg::ST_STOP;
                end
            end
            shs_pkg::ST_HALT:
            begin
                if (irq_pending)
                begin
                    s_next.state    = shs_pkg::ST_RUN;
                    s_next.res_vec  = irq_enabled;
                    s_next.res_next = !irq_enabled;
                end
            end
            shs_pkg::ST_STOP:
            begin
                if (irq_pending)
                    s_next.state = shs_pkg::ST_STAB;
            end
            shs_pkg::ST_STAB:
            begin
                // Only the crystal needs the counted wait; others settle quickly.
                s_next.wait_cnt = s_reg.wait_cnt + 1'b1;
                if (s_reg.src == shs_pkg::SRC_XTAL)
                    sleep_n = !stab_done;
                else
                    sleep_n = int'(s_reg.wait_cnt) < shs_pkg::FAST_SETTLE_CYC - 1;
                if (!sleep_n)
                begin
                    s_next.state    = shs_pkg::ST_RUN;
                    s_next.res_vec  = irq_enabled;
                    s_next.res_next = !irq_enabled;
                end
            end
            default:
                s_next.state = shs_pkg::ST_RUN;
        endcase

        // Outputs follow the next state so they change with it.
        s_next.cpu_clk_en   = s_next.state == shs_pkg::ST_RUN;
        s_next.flash_run    = s_next.cpu_clk_en;
        s_next.flash_lowpwr = s_next.state == shs_pkg::ST_HALT
                           && s_next.src == shs_pkg::SRC_SUB;
        s_next.osc_en       = osc_req;
        s_next.periph       = '1;
        s_next.slow_en      = s_reg.opt[shs_pkg::OPT_WDT_EN];
        s_next.wdt_run      = s_reg.opt[shs_pkg::OPT_WDT_EN];
        case (s_next.state)
            shs_pkg::ST_HALT:
            begin
                // The clock that fed the CPU cannot be stopped.
                case (s_next.src)
                    shs_pkg::SRC_FAST: s_next.osc_en.fast = 1'b1;
                    shs_pkg::SRC_DSC:  s_next.osc_en.dsc  = 1'b1;
                    shs_pkg::SRC_XTAL: s_next.osc_en.xtal = 1'b1;
                    shs_pkg::SRC_EXT:  s_next.osc_en.ext  = 1'b1;
                    default:           s_next.osc_en.sub  = 1'b1;
                endcase
                // External clock and crystal share pins and exclude each other.
                if (s_next.src == shs_pkg::SRC_XTAL)
                    s_next.osc_en.ext = 1'b0;
                if (s_next.src == shs_pkg::SRC_EXT)
                    s_next.osc_en.xtal = 1'b0;
                if (s_next.src == shs_pkg::SRC_SUB)
                begin
                    s_next.periph.inverter = 1'b0;
                    s_next.periph.adc      = 1'b0;
                end
                s_next.slow_en = wdt_opt_on;
                s_next.wdt_run = wdt_opt_on;
            end
            shs_pkg::ST_STOP:
            begin
                s_next.osc_en.fast          = 1'b0;
                s_next.osc_en.dsc           = 1'b0;
                s_next.osc_en.xtal          = 1'b0;
                s_next.osc_en.ext           = 1'b0;
                s_next.periph.timer_array   = 1'b0;
                s_next.periph.inverter      = 1'b0;
                s_next.periph.adc           = 1'b0;
                s_next.periph.amp           = 1'b0;
                s_next.periph.comp          = 1'b0;
                s_next.periph.serial_array  = 1'b0;
                s_next.periph.muldiv        = 1'b0;
                s_next.periph.dma           = 1'b0;
                s_next.slow_en              = wdt_opt_on;
                s_next.wdt_run              = wdt_opt_on;
            end
            shs_pkg::ST_STAB:
            begin
                // The restarting source runs, the peripherals except rtc and ext_irq wait for the CPU.
                if (s_next.src == shs_pkg::SRC_FAST)
                    s_next.osc_en.fast = 1'b1;
                if (s_next.src == shs_pkg::SRC_XTAL)
                    s_next.osc_en.xtal = 1'b1;
                if (s_next.src == shs_pkg::SRC_EXT)
                    s_next.osc_en.ext = 1'b1;
                s_next.osc_en.dsc          = 1'b0;
                s_next.periph.timer_array  = 1'b0;
                s_next.periph.inverter     = 1'b0;
                s_next.periph.adc          = 1'b0;
                s_next.periph.amp          = 1'b0;
                s_next.periph.comp         = 1'b0;
                s_next.periph.serial_array = 1'b0;
                s_next.periph.muldiv       = 1'b0;
                s_next.periph.dma          = 1'b0;
                s_next.slow_en             = wdt_opt_on;
                s_next.wdt_run             = wdt_opt_on;
            end
            default:
            begin
                s_next.slow_en = s_reg.opt[shs_pkg::OPT_WDT_EN];
            end
        endcase
    end

    // ==================================================
    // State register
    // ==================================================
    // Reset drops any sleep state and restarts from the vector.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            s_reg            <= '0;
            s_reg.state      <= shs_pkg::ST_RUN;
            s_reg.sel        <= shs_pkg::SEL_RST;
            s_reg.opt        <= shs_pkg::OPT_RST;
            s_reg.cpu_clk_en <= 1'b1;
            s_reg.flash_run  <= 1'b1;
            s_reg.periph     <= '1;
            s_reg.boot       <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    // ==================================================
    // Outputs
    // ==================================================
    assign reg_rdata            = s_reg.rdata;
    assign cpu_clk_en           = s_reg.cpu_clk_en;
    assign resume_vectored      = s_reg.res_vec;
    assign resume_next          = s_reg.res_next;
    assign boot_from_vector     = s_reg.boot;
    assign osc_en               = s_reg.osc_en;
    assign internal_slow_osc_en = s_reg.slow_en;
    assign flash_run            = s_reg.flash_run;
    assign flash_lowpwr         = s_reg.flash_lowpwr;
    assign wdt_run              = s_reg.wdt_run;
    assign periph_en            = s_reg.periph;

    // ==================================================
    // Checks
    // ==================================================
    // Cycles spent in the wait state for sources that need no counted crystal wait.
    localparam int short_wake_cyc = shs_pkg::FAST_SETTLE_CYC;

    a_halt_entry: assert property (@(posedge clock) disable iff (srst)
        s_reg.state == shs_pkg::ST_RUN && halt_exec |=> s_reg.state == shs_pkg::ST_HALT)
        else $error("halt not entered");

    a_halt_gating: assert property (@(posedge clock) disable iff (srst)
        s_reg.state == shs_pkg::ST_HALT |-> !cpu_clk_en && !flash_run)
        else $error("cpu or flash runs in light sleep");

    a_halt_keep_src: assert property (@(posedge clock) disable iff (srst)
        s_reg.state == shs_pkg::ST_HALT && s_reg.src == shs_pkg::SRC_XTAL |-> osc_en.xtal)
        else $error("cpu main clock stopped in light sleep");

    a_sleep_wdt: assert property (@(posedge clock) disable iff (srst)
        s_reg.state != shs_pkg::ST_RUN ##1 s_reg.state != shs_pkg::ST_RUN
        |-> wdt_run == wdt_opt_on && internal_slow_osc_en == wdt_opt_on)
        else $error("watchdog state wrong in sleep");

    a_sub_halt: assert property (@(posedge clock) disable iff (srst)
        s_reg.state == shs_pkg::ST_HALT && s_reg.src == shs_pkg::SRC_SUB
        |-> flash_lowpwr && !periph_en.adc && !periph_en.inverter && periph_en.timer_array)
        else $error("subsystem light sleep outputs wrong");

    a_halt_wake: assert property (@(posedge clock) disable iff (srst)
        s_reg.state == shs_pkg::ST_HALT && irq_pending
        |=> cpu_clk_en && (resume_vectored == $past(irq_enabled)) && (resume_next != resume_vectored))
        else $error("light sleep wake wrong");

    a_stop_refused: assert property (@(posedge clock) disable iff (srst)
        s_reg.state == shs_pkg::ST_RUN && !halt_exec && stop_exec && !stop_ok
        |=> s_reg.state == shs_pkg::ST_RUN)
        else $error("stop accepted from wrong clock");

    a_stop_pending: assert property (@(posedge clock) disable iff (srst)
        s_reg.state == shs_pkg::ST_RUN && !halt_exec && stop_exec && stop_ok && irq_pending
        |=> s_reg.state == shs_pkg::ST_STAB)
        else $error("pending interrupt did not skip deep sleep");

    a_stop_clocks: assert property (@(posedge clock) disable iff (srst)
        s_reg.state == shs_pkg::ST_STOP
        |-> !osc_en.fast && !osc_en.xtal && !osc_en.ext && !osc_en.dsc && periph_en.rtc && !periph_en.dma)
        else $error("deep sleep clocks wrong");

    a_short_wait: assert property (@(posedge clock) disable iff (srst)
        $rose(s_reg.state == shs_pkg::ST_STAB) && s_reg.src != shs_pkg::SRC_XTAL
        |-> ##short_wake_cyc s_reg.state == shs_pkg::ST_RUN)
        else $error("short wake wait too long");

    a_xtal_wait: assert property (@(posedge clock) disable iff (srst)
        s_reg.state == shs_pkg::ST_STAB && s_reg.src == shs_pkg::SRC_XTAL && !stab_done
        |=> !cpu_clk_en)
        else $error("resumed before stabilization");
endmodule // shs_ctrl

// *** tb/shs_xtal_model.sv ***
// Crystal oscillator model that swings only while the controller enables it.
`timescale 1ns/10ps
module shs_xtal_model (
    // Clock and enable
    input  wire logic clock,
    input  wire logic run,
    // Crystal pin
    output logic      crystal_main_clock
);
    logic [1:0] div_reg;
    // ==================================================
    // Oscillator
    // ==================================================
    // A stopped crystal stays low, so no stray edge can shorten the wait.
    always_ff @(posedge clock)
    begin
        div_reg            <= run ? div_reg + 2'h1 : 2'h0;
        crystal_main_clock <= run & div_reg[1];
    end
endmodule // shs_xtal_model

// *** tb/tb_top.sv ***
// Self-checking testbench of the standby controller.
`timescale 1ns/10ps
module tb_top;
    logic              clock, srst, reg_we, reg_re, halt_exec, stop_exec, irq_pending, irq_enabled, xtal;
    logic              cpu_clk_en, resume_vectored, resume_next, boot_from_vector, slow_en;
    logic              flash_run, flash_lowpwr, wdt_run;
    logic [1:0]        reg_addr;
    logic [7:0]        reg_wdata, reg_rdata;
    shs_pkg::shs_src_t src;
    shs_pkg::shs_osc_t osc_req, osc_en;
    shs_pkg::shs_periph_t periph_en;
    int                err_count, n_tests, cyc, i;
    shs_ctrl u_dut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .halt_exec(halt_exec), .stop_exec(stop_exec),
        .irq_pending(irq_pending), .irq_enabled(irq_enabled), .cpu_clk_src(src), .cpu_clk_en(cpu_clk_en),
        .resume_vectored(resume_vectored), .resume_next(resume_next), .boot_from_vector(boot_from_vector),
        .osc_req(osc_req), .crystal_main_clock(xtal), .osc_en(osc_en), .internal_slow_osc_en(slow_en),
        .flash_run(flash_run), .flash_lowpwr(flash_lowpwr), .wdt_run(wdt_run), .periph_en(periph_en));
    shs_xtal_model u_xtal (.clock(clock), .run(osc_en.xtal), .crystal_main_clock(xtal));
    // ==================================================
    // Helpers
    // ==================================================
    task automatic end_of_test();
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("Error %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_we <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge clock);
        reg_we <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_re <= 1'b1; reg_addr <= a;
        @(posedge clock);
        reg_re <= 1'b0;
        #1 chk(10'(reg_rdata), 10'(exp));
    endtask
    task automatic instr(input logic h);
        @(posedge clock);
        halt_exec <= h; stop_exec <= !h;
        @(posedge clock);
        halt_exec <= 1'b0; stop_exec <= 1'b0;
        #1;
    endtask
    // Raise an interrupt and count cycles until the CPU clock returns.
    task automatic wake(input int lim);
        @(posedge clock);
        irq_pending <= 1'b1;
        i = 0;
        do begin @(posedge clock); #1; i++; end while (cpu_clk_en !== 1'b1 && i < lim);
        chk(10'({resume_vectored, resume_next}), irq_enabled ? 10'h2 : 10'h1);
        @(posedge clock);
        irq_pending <= 1'b0;
    endtask
    initial
    begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    // The longest run is one crystal wait of about a thousand cycles.
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end
    // ==================================================
    // Tests
    // ==================================================
    initial
    begin
        {srst, reg_we, reg_re, halt_exec, stop_exec, irq_pending, irq_enabled} = 7'h40;
        reg_addr = 2'h0; reg_wdata = 8'h00; src = shs_pkg::SRC_FAST; osc_req = 5'h11;
        err_count = 0; n_tests = 0; cyc = 0;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        rd(shs_pkg::ADDR_SEL, 8'h07);
        chk(10'(boot_from_vector), 10'h0);
        rd(shs_pkg::ADDR_STATUS, 8'h00);
        for (int s = 0; s < 5; s++)
        begin
            src <= shs_pkg::shs_src_t'(s); irq_enabled <= s[0];
            instr(1'b1);
            chk(10'({cpu_clk_en, flash_run, flash_lowpwr, periph_en.adc}), s == 4 ? 10'h2 : 10'h1);
            chk(10'(osc_en.fast), 10'(s < 2 || osc_req.fast));
            rd(shs_pkg::ADDR_STATE, 8'h01);
            wake(5);
            chk(10'(i), 10'h1);
        end
        src <= shs_pkg::SRC_FAST;
        for (int k = 0; k < 5; k++)
        begin
            wr(shs_pkg::ADDR_OPT, k % 2 ? 8'h10 : 8'h11);
            instr(1'b0);
            chk(10'({cpu_clk_en, osc_en.fast, osc_en.sub}), 10'(osc_req.sub));
            chk(10'({wdt_run, slow_en}), k % 2 ? 10'h0 : 10'h3);
            chk(10'(periph_en), 10'h003);
            wake(60);
            chk(10'(i), 10'(shs_pkg::FAST_SETTLE_CYC + 1));
            chk(10'(periph_en), 10'h3ff);
        end
        src <= shs_pkg::SRC_SUB;
        instr(1'b0);
        chk(10'(cpu_clk_en), 10'h1);
        src <= shs_pkg::SRC_FAST; irq_pending <= 1'b1;
        instr(1'b0);
        rd(shs_pkg::ADDR_STATE, 8'h03);
        wake(60);
        wr(shs_pkg::ADDR_SEL, 8'h00);
        src <= shs_pkg::SRC_XTAL;
        instr(1'b0);
        wake(3000);
        chk(10'(i > 1000 && i < 1200), 10'h1);
        rd(shs_pkg::ADDR_STATUS, 8'h80);
        instr(1'b1);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        #1 chk(10'({cpu_clk_en, boot_from_vector}), 10'h3);
        rd(shs_pkg::ADDR_SEL, 8'h07);
        end_of_test();
    end
endmodule // tb_top
